//--- hw/bpc_pkg.sv
// Package with register map, field layout, timing and types of the block.
package bpc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets.
    localparam logic [31:0] BPC_CTRL_OFS = 32'h0000_0000;
    localparam logic [31:0] BPC_CONFIG_OFS = 32'h0000_0004;
    localparam logic [31:0] BPC_IRQ_STAT_OFS = 32'h0000_0008;
    localparam logic [31:0] BPC_IRQ_MASK_OFS = 32'h0000_000c;
    localparam logic [31:0] BPC_LIVE_OFS = 32'h0000_0010;

    ////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int BPC_CTRL_IDLE_BIT = 0;
    localparam int BPC_CFG_TA_LSB = 0;
    localparam int BPC_CFG_BA_LSB = 8;
    localparam int BPC_CFG_RED_BIT = 11;
    localparam int BPC_CFG_DUAL_BIT = 12;
    localparam int BPC_CFG_QUIET_BIT = 13;
    localparam int BPC_CFG_VALID_BIT = 14;
    localparam int BPC_LIVE_TA_LSB = 0;
    localparam int BPC_LIVE_SW_LSB = 8;
    localparam int BPC_LIVE_JMP_BIT = 16;
    localparam int BPC_IRQ_TEL_BIT = 0;
    localparam int BPC_IRQ_QUIET_BIT = 1;
    localparam int BPC_IRQ_RESUME_BIT = 2;
    localparam int BPC_IRQ_BADTA_BIT = 3;
    localparam int BPC_SW_RED_IDX = 4;
    localparam int BPC_SW_SAVE_IDX = 7;

    ////////////////////////////////////////////////////////////////////////
    // Reset values and limits.
    localparam logic [7:0] BPC_TA_RESET = 8'h5a;
    localparam logic [7:0] BPC_TA_MAX = 8'h63;
    localparam logic [3:0] BPC_IRQ_MASK_RESET = 4'h0;

    ////////////////////////////////////////////////////////////////////////
    // Timing.
    localparam int BPC_CLK_NS = 100;
    localparam int BPC_STRETCH_US = 20;
    localparam logic [15:0] BPC_STRETCH_CYCLES =
        16'((BPC_STRETCH_US * 1000) / BPC_CLK_NS);
    localparam int BPC_BLINK_MS = 250;
    localparam int BPC_BLINK_CYCLES = (BPC_BLINK_MS * 1000000) / BPC_CLK_NS;

    ////////////////////////////////////////////////////////////////////////
    // Types.
    typedef enum logic [3:0] {
        BPC_RUN = 4'b0001,
        BPC_WAIT_ON = 4'b0010,
        BPC_WAIT_OFF = 4'b0100,
        BPC_WAIT_REON = 4'b1000
    } bpc_mode_e;

    typedef struct packed {
        logic [7:0] station;
        logic dual;
        logic [2:0] bus_addr;
        logic redund;
    } bpc_cfg_s;

    typedef struct packed {
        logic fault;
        logic data;
        logic master;
        logic busy;
        logic bus_a;
        logic bus_b;
    } bpc_led_s;

    typedef struct packed {
        logic [15:0] cnt;
    } bpc_stretch_s;

endpackage : bpc_pkg

//--- hw/bpc_pulse_stretch.sv
// Pulse stretcher that keeps an indicator lit long enough to be seen.
`timescale 1ns/10ps
`default_nettype none
module bpc_pulse_stretch
    import bpc_pkg::*;
#(
    parameter logic [15:0] LEN = BPC_STRETCH_CYCLES
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Trigger and stretched level.
    input wire logic trig,
    output logic stretched
);

    bpc_stretch_s st_reg;
    bpc_stretch_s st_next;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_next = st_reg;
        if (trig) begin
            st_next.cnt = LEN;
        end else if (st_reg.cnt != 16'h0000) begin
            st_next.cnt = st_reg.cnt - 16'h0001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign stretched = (st_reg.cnt != 16'h0000);

    ////////////////////////////////////////////////////////////////////////
    property p_stretch_hold;
        @(posedge hclk) disable iff (!hresetn)
        trig |=> stretched [*2];
    endproperty
    a_stretch_hold: assert property (p_stretch_hold)
        else $error("Stretched pulse too short.");

    property p_stretch_end;
        @(posedge hclk) disable iff (!hresetn)
        (!trig && st_reg.cnt == 16'h0001) |=> !stretched;
    endproperty
    a_stretch_end: assert property (p_stretch_end)
        else $error("Stretched pulse too long.");

endmodule : bpc_pulse_stretch
`default_nettype wire

//--- hw/bpc_config_capture.sv
// Switch capture, idle and save sequence, indicators and AHB-Lite registers.
// Behaviour
// - Station address read from eight-bit switch bank.
// - Station address defaults ninety; valid range 0-99, except station 0 with bus address 0.
// - Bus address from switches 1-3, off reads one.
// - Switch 5 on selects redundant remote bus.
// - Changed bus or redundancy switches enter idle.
// - Save on-off-on loads settings, resumes normal operation.
// - Jumper open answers stations N and N+1.
// - Second station address raises no host interrupt.
// - Fault indicator steady during sequencer abort, also lit for a stretched time after each sequencer fault pulse.
// - Active bus indicator steady, passive one flashes.
// - Master indicator lit while holding bus master.
// - Data indicator pulses with local-bus transfers.
// - Busy indicator lights during processor read cycles.
`timescale 1ns/10ps
`default_nettype none
module bpc_config_capture
    import bpc_pkg::*;
#(
    parameter int unsigned BLINK_CYCLES = BPC_BLINK_CYCLES
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Operator switches and jumper.
    input wire logic [7:0] station_address_switch_bank,
    input wire logic address_mode_jumper,
    input wire logic [7:0] front_switch_on,
    // Incoming telegram addresses.
    input wire logic telegram_valid,
    input wire logic [2:0] telegram_bus_addr,
    input wire logic [7:0] telegram_station,
    // Bus interface logic status.
    input wire logic seq_abort,
    input wire logic seq_fault_pulse,
    input wire logic active_bus_b,
    input wire logic master_status,
    input wire logic data_xfer_pulse,
    input wire logic cpu_read_cycle,
    // Configuration and matches.
    output bpc_cfg_s cfg,
    output logic quiet,
    output logic hit_primary,
    output logic hit_secondary,
    // Indicators and interrupt.
    output bpc_led_s led,
    output logic irq
);

    typedef struct packed {
        bpc_mode_e mode;
        logic captured;
        bpc_cfg_s cfg;
        logic st_valid;
        logic force_idle;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        logic dph;
        logic dwr;
        logic [31:0] daddr;
        logic [31:0] rdata;
        logic hit_p;
        logic hit_s;
        logic [31:0] blink_cnt;
        logic blink;
        bpc_led_s led;
    } bpc_top_s;

    bpc_top_s st_reg;
    bpc_top_s st_next;
    logic [2:0] live_ba;
    logic live_red;
    logic save_on;
    logic take;
    logic fault_str;
    logic data_str;
    logic busy_str;

    ////////////////////////////////////////////////////////////////////////
    // Indicator stretchers.
    bpc_pulse_stretch #(.LEN(BPC_STRETCH_CYCLES)) u_fault_str (
        .hclk(hclk),
        .hresetn(hresetn),
        .trig(seq_fault_pulse),
        .stretched(fault_str)
    );

    bpc_pulse_stretch #(.LEN(BPC_STRETCH_CYCLES)) u_data_str (
        .hclk(hclk),
        .hresetn(hresetn),
        .trig(data_xfer_pulse),
        .stretched(data_str)
    );

    bpc_pulse_stretch #(.LEN(BPC_STRETCH_CYCLES)) u_busy_str (
        .hclk(hclk),
        .hresetn(hresetn),
        .trig(cpu_read_cycle),
        .stretched(busy_str)
    );

    ////////////////////////////////////////////////////////////////////////
    // Live switch decode.
    assign live_ba = ~front_switch_on[2:0];
    assign live_red = front_switch_on[BPC_SW_RED_IDX];
    assign save_on = front_switch_on[BPC_SW_SAVE_IDX];
    assign take = hsel && hready && htrans[1];

    ////////////////////////////////////////////////////////////////////////
    // Next state.
    always_comb begin
        logic [31:0] rd;
        logic [3:0] set;
        logic [3:0] clr;
        rd = 32'h0000_0000;
        set = 4'h0;
        clr = 4'h0;
        st_next = st_reg;

        // Register read data, captured in the address phase.
        case (haddr)
            BPC_CTRL_OFS: begin
                rd[BPC_CTRL_IDLE_BIT] = st_reg.force_idle;
            end
            BPC_CONFIG_OFS: begin
                rd[BPC_CFG_TA_LSB +: 8] = st_reg.cfg.station;
                rd[BPC_CFG_BA_LSB +: 3] = st_reg.cfg.bus_addr;
                rd[BPC_CFG_RED_BIT] = st_reg.cfg.redund;
                rd[BPC_CFG_DUAL_BIT] = st_reg.cfg.dual;
                rd[BPC_CFG_QUIET_BIT] = (st_reg.mode != BPC_RUN);
                rd[BPC_CFG_VALID_BIT] = st_reg.st_valid;
            end
            BPC_IRQ_STAT_OFS: begin
                rd[3:0] = st_reg.irq_stat;
            end
            BPC_IRQ_MASK_OFS: begin
                rd[3:0] = st_reg.irq_mask;
            end
            BPC_LIVE_OFS: begin
                rd[BPC_LIVE_TA_LSB +: 8] = station_address_switch_bank;
                rd[BPC_LIVE_SW_LSB +: 8] = front_switch_on;
                rd[BPC_LIVE_JMP_BIT] = address_mode_jumper;
            end
            default: begin
                rd = 32'h0000_0000;
            end
        endcase

        st_next.dph = take;
        if (take) begin
            st_next.dwr = hwrite;
            st_next.daddr = haddr;
            if (!hwrite) begin
                st_next.rdata = rd;
                if (haddr == BPC_IRQ_STAT_OFS) begin
                    clr = 4'hf;
                end
            end
        end

        // Writes land in the data phase.
        if (st_reg.dph && st_reg.dwr) begin
            case (st_reg.daddr)
                BPC_CTRL_OFS: begin
                    st_next.force_idle = hwdata[BPC_CTRL_IDLE_BIT];
                end
                BPC_IRQ_MASK_OFS: begin
                    st_next.irq_mask = hwdata[3:0];
                end
                default: begin
                    st_next.force_idle = st_reg.force_idle;
                end
            endcase
        end

        // One-time capture after reset release.
        if (!st_reg.captured) begin
            st_next.captured = 1'b1;
            st_next.cfg.station = station_address_switch_bank;
            st_next.cfg.dual = ~address_mode_jumper;
            st_next.cfg.bus_addr = live_ba;
            st_next.cfg.redund = live_red;
            st_next.st_valid = (station_address_switch_bank <= BPC_TA_MAX)
                && !(station_address_switch_bank == 8'h00
                && live_ba == 3'h0);
            set[BPC_IRQ_BADTA_BIT] = !st_next.st_valid;
        end

        // Idle and save sequence.
        case (st_reg.mode)
            BPC_RUN: begin
                if (st_reg.captured && (live_ba != st_reg.cfg.bus_addr
                    || live_red != st_reg.cfg.redund
                    || st_reg.force_idle)) begin
                    st_next.mode = BPC_WAIT_ON;
                    set[BPC_IRQ_QUIET_BIT] = 1'b1;
                end
            end
            BPC_WAIT_ON: begin
                if (save_on) begin
                    st_next.mode = BPC_WAIT_OFF;
                end
            end
            BPC_WAIT_OFF: begin
                if (!save_on) begin
                    st_next.mode = BPC_WAIT_REON;
                end
            end
            BPC_WAIT_REON: begin
                if (save_on) begin
                    st_next.mode = BPC_RUN;
                    st_next.cfg.bus_addr = live_ba;
                    st_next.cfg.redund = live_red;
                    st_next.st_valid = (st_reg.cfg.station <= BPC_TA_MAX)
                        && !(st_reg.cfg.station == 8'h00
                        && live_ba == 3'h0);
                    set[BPC_IRQ_RESUME_BIT] = 1'b1;
                    set[BPC_IRQ_BADTA_BIT] = !st_next.st_valid;
                end
            end
            default: begin
                st_next.mode = BPC_RUN;
            end
        endcase

        // Telegram address match, only in normal operation.
        st_next.hit_p = telegram_valid && st_reg.captured
            && st_reg.mode == BPC_RUN
            && telegram_bus_addr == st_reg.cfg.bus_addr
            && telegram_station == st_reg.cfg.station;
        st_next.hit_s = telegram_valid && st_reg.captured
            && st_reg.mode == BPC_RUN && st_reg.cfg.dual
            && telegram_bus_addr == st_reg.cfg.bus_addr
            && telegram_station == 8'(st_reg.cfg.station + 8'h01);
        set[BPC_IRQ_TEL_BIT] = st_next.hit_p;

        // Sticky status: a new event wins over a read clear.
        st_next.irq_stat = (st_reg.irq_stat & ~clr) | set;

        // Flash timebase for the passive bus indicator.
        if (st_reg.blink_cnt >= 32'(BLINK_CYCLES - 1)) begin
            st_next.blink_cnt = 32'h0000_0000;
            st_next.blink = ~st_reg.blink;
        end else begin
            st_next.blink_cnt = st_reg.blink_cnt + 32'h0000_0001;
        end

        // Indicators.
        st_next.led.fault = seq_abort || fault_str;
        st_next.led.data = data_str;
        st_next.led.master = master_status;
        st_next.led.busy = busy_str;
        st_next.led.bus_a = active_bus_b ? st_reg.blink : 1'b1;
        st_next.led.bus_b = active_bus_b ? 1'b1 : st_reg.blink;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= '0;
            st_reg.mode <= BPC_RUN;
            st_reg.cfg.station <= BPC_TA_RESET;
            st_reg.irq_mask <= BPC_IRQ_MASK_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.
    assign hrdata = st_reg.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign cfg = st_reg.cfg;
    assign quiet = (st_reg.mode != BPC_RUN);
    assign hit_primary = st_reg.hit_p;
    assign hit_secondary = st_reg.hit_s;
    assign led = st_reg.led;
    assign irq = |(st_reg.irq_stat & st_reg.irq_mask);

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    property p_idle_entry;
        @(posedge hclk) disable iff (!hresetn)
        (st_reg.mode == BPC_RUN && st_reg.captured
            && live_ba != st_reg.cfg.bus_addr)
        |=> st_reg.mode == BPC_WAIT_ON && st_reg.irq_stat[1];
    endproperty
    a_idle_entry: assert property (p_idle_entry)
        else $error("Bus address change did not enter idle.");

    property p_save_commit;
        @(posedge hclk) disable iff (!hresetn)
        (st_reg.mode == BPC_WAIT_REON && save_on)
        |=> st_reg.mode == BPC_RUN
            && st_reg.cfg.bus_addr == $past(live_ba)
            && st_reg.cfg.redund == $past(live_red);
    endproperty
    a_save_commit: assert property (p_save_commit)
        else $error("Save sequence did not load settings.");

    property p_capture;
        @(posedge hclk) disable iff (!hresetn)
        !st_reg.captured |=> st_reg.captured
            && st_reg.cfg.station == $past(station_address_switch_bank)
            && st_reg.cfg.dual == !$past(address_mode_jumper)
            && st_reg.cfg.bus_addr == ~$past(front_switch_on[2:0]);
    endproperty
    a_capture: assert property (p_capture)
        else $error("Reset capture wrong.");

    property p_station_held;
        @(posedge hclk) disable iff (!hresetn)
        st_reg.captured |=> $stable(st_reg.cfg.station)
            && $stable(st_reg.cfg.dual);
    endproperty
    a_station_held: assert property (p_station_held)
        else $error("Station address changed after capture.");

    property p_no_second;
        @(posedge hclk) disable iff (!hresetn)
        !st_reg.cfg.dual |-> !hit_secondary;
    endproperty
    a_no_second: assert property (p_no_second)
        else $error("Second station answered in single mode.");

    property p_tel_irq;
        @(posedge hclk) disable iff (!hresetn)
        $rose(st_reg.irq_stat[0]) |-> hit_primary;
    endproperty
    a_tel_irq: assert property (p_tel_irq)
        else $error("Telegram status set without primary hit.");

    property p_fault_led;
        @(posedge hclk) disable iff (!hresetn)
        seq_abort |=> led.fault;
    endproperty
    a_fault_led: assert property (p_fault_led)
        else $error("Fault indicator dark during abort.");

    property p_bus_led;
        @(posedge hclk) disable iff (!hresetn)
        !active_bus_b [*2] |=> led.bus_a;
    endproperty
    a_bus_led: assert property (p_bus_led)
        else $error("Active bus A indicator not steady.");

    property p_master_led;
        @(posedge hclk) disable iff (!hresetn)
        ##1 led.master == $past(master_status);
    endproperty
    a_master_led: assert property (p_master_led)
        else $error("Master indicator does not follow status.");

    property p_valid_range;
        @(posedge hclk) disable iff (!hresetn)
        (st_reg.captured && st_reg.cfg.station > BPC_TA_MAX)
        |-> !st_reg.st_valid;
    endproperty
    a_valid_range: assert property (p_valid_range)
        else $error("Station address above range marked valid.");

endmodule : bpc_config_capture
`default_nettype wire

//--- verif/bpc_panel_model.sv
// Front panel switches and jumper as the operator sets them.
`timescale 1ns/10ps
`default_nettype none
module bpc_panel_model
    import bpc_pkg::*;
(
    // Clock.
    input wire logic hclk,
    // Switch and jumper levels.
    output logic [7:0] station_address_switch_bank,
    output logic address_mode_jumper,
    output logic [7:0] front_switch_on
);
    initial begin
        station_address_switch_bank = 8'h5a;
        address_mode_jumper = 1'b0;
        front_switch_on = 8'h11;
    end

    ////////////////////////////////////////////////////////////////////////
    // Station address and mode are meant to change only around a reset.
    task automatic commission(input logic [7:0] st, input logic jmp);
        station_address_switch_bank <= st;
        address_mode_jumper <= jmp;
    endtask : commission

    // Bus address zero is never offered together with station zero.
    task automatic set_front(input logic [7:0] sw);
        if (!(station_address_switch_bank == 8'h00 && sw[2:0] == 3'h7)) begin
            front_switch_on <= sw;
        end
    endtask : set_front

    // Save switch goes on, off, on.
    task automatic save_toggle();
        int k;
        for (k = 0; k < 3; k++) begin
            @(posedge hclk);
            front_switch_on[BPC_SW_SAVE_IDX] <= ~k[0];
            repeat (2) @(posedge hclk);
        end
    endtask : save_toggle
endmodule : bpc_panel_model
`default_nettype wire

//--- verif/tb_bpc_config_capture.sv
// Self-checking testbench of the configuration capture block.
`timescale 1ns/10ps
`default_nettype none
module tb_bpc_config_capture
    import bpc_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic [7:0] bank;
    logic jumper;
    logic [7:0] front;
    logic tv = 1'b0;
    logic [2:0] tba = 3'h6;
    logic [7:0] tst = 8'h0;
    logic abort = 1'b0;
    logic fpulse = 1'b0;
    logic bus_b = 1'b0;
    logic mst = 1'b0;
    logic dpulse = 1'b0;
    logic rd = 1'b0;
    bpc_cfg_s cfg;
    logic quiet;
    logic hp;
    logic hs;
    bpc_led_s led;
    logic irq;
    int bad_count = 0;
    int checked = 0;
    logic [31:0] r;

    always #50 hclk = ~hclk;

    bpc_panel_model i_bpc_panel_model (.hclk(hclk),
        .station_address_switch_bank(bank), .address_mode_jumper(jumper),
        .front_switch_on(front));

    bpc_config_capture #(.BLINK_CYCLES(8)) i_bpc_config_capture (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
        .station_address_switch_bank(bank), .address_mode_jumper(jumper),
        .front_switch_on(front), .telegram_valid(tv),
        .telegram_bus_addr(tba), .telegram_station(tst),
        .seq_abort(abort), .seq_fault_pulse(fpulse), .active_bus_b(bus_b),
        .master_status(mst), .data_xfer_pulse(dpulse),
        .cpu_read_cycle(rd), .cfg(cfg), .quiet(quiet), .hit_primary(hp),
        .hit_secondary(hs), .led(led), .irq(irq));

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // A wait that ran out of its bound ends the run.
    task automatic bound(input logic ok);
        if (ok !== 1'b1) begin
            check(32'h0, 32'h1);
            give_verdict();
        end
    endtask : bound

    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1 && n < 100) begin
            n++;
            @(posedge hclk);
        end
        bound(hready);
    endtask : wait_ready

    task automatic ahb(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] rdat);
        @(posedge hclk);
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rdat = hrdata;
        check(hresp, 1'b0);
    endtask : ahb

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] v;
        ahb(1'b0, a, 32'h0, v);
        check(v, exp);
    endtask : rd_chk

    function automatic logic [31:0] cfgw(input logic [7:0] st,
        input logic [2:0] ba, input int red, dual, qt, valid);
        return 32'(st) | (32'(ba) << BPC_CFG_BA_LSB)
            | (32'(red) << BPC_CFG_RED_BIT) | (32'(dual) << BPC_CFG_DUAL_BIT)
            | (32'(qt) << BPC_CFG_QUIET_BIT)
            | (32'(valid) << BPC_CFG_VALID_BIT);
    endfunction : cfgw

    task automatic do_reset();
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
    endtask : do_reset

    task automatic tel(input logic [7:0] st);
        @(posedge hclk);
        tv <= 1'b1;
        tst <= st;
        @(posedge hclk);
        tv <= 1'b0;
        #1;
    endtask : tel

    task automatic wait_quiet(input logic lvl);
        int n;
        for (n = 0; n < 20 && quiet !== lvl; n++) @(posedge hclk);
        #1;
        bound(quiet === lvl);
    endtask : wait_quiet

    ////////////////////////////////////////////////////////////////////////
    task automatic t_capture();
        rd_chk(BPC_CONFIG_OFS, cfgw(8'h5a, 3'h6, 1, 1, 0, 1));
        rd_chk(BPC_LIVE_OFS, 32'h0000_115a);
        rd_chk(BPC_IRQ_MASK_OFS, 32'h0);
        ahb(1'b1, BPC_IRQ_MASK_OFS, 32'hf, r);
        rd_chk(BPC_IRQ_MASK_OFS, 32'hf);
        ahb(1'b1, BPC_IRQ_MASK_OFS, 32'h0, r);
        rd_chk(32'h0000_0020, 32'h0);
        rd_chk(BPC_IRQ_STAT_OFS, 32'h0);
        $display("Capture test done");
    endtask : t_capture

    task automatic t_match();
        tel(8'h5b);
        check({hp, hs}, 2'b01);
        rd_chk(BPC_IRQ_STAT_OFS, 32'h0);
        tel(8'h5a);
        check({hp, hs, irq}, 3'b100);
        rd_chk(BPC_IRQ_STAT_OFS, 32'h1);
        $display("Match test done");
    endtask : t_match

    task automatic t_idle();
        ahb(1'b1, BPC_IRQ_MASK_OFS, 32'h2, r);
        @(posedge hclk);
        i_bpc_panel_model.set_front(8'h10);
        wait_quiet(1'b1);
        check(irq, 1'b1);
        rd_chk(BPC_IRQ_STAT_OFS, 32'h2);
        #1;
        check(irq, 1'b0);
        tel(8'h5a);
        check({hp, hs}, 2'b00);
        rd_chk(BPC_CONFIG_OFS, cfgw(8'h5a, 3'h6, 1, 1, 1, 1));
        i_bpc_panel_model.save_toggle();
        wait_quiet(1'b0);
        rd_chk(BPC_CONFIG_OFS, cfgw(8'h5a, 3'h7, 1, 1, 0, 1));
        rd_chk(BPC_IRQ_STAT_OFS, 32'h4);
        ahb(1'b1, BPC_CTRL_OFS, 32'h1, r);
        wait_quiet(1'b1);
        rd_chk(BPC_CTRL_OFS, 32'h1);
        ahb(1'b1, BPC_CTRL_OFS, 32'h0, r);
        i_bpc_panel_model.set_front(8'h80);
        i_bpc_panel_model.save_toggle();
        wait_quiet(1'b0);
        rd_chk(BPC_CONFIG_OFS, cfgw(8'h5a, 3'h7, 0, 1, 0, 1));
        rd_chk(BPC_IRQ_STAT_OFS, 32'h6);
        $display("Idle test done");
    endtask : t_idle

    task automatic t_leds();
        int n;
        int tg;
        logic a_ok;
        int ph;
        logic prev;
        @(posedge hclk);
        abort <= 1'b1;
        mst <= 1'b1;
        fpulse <= 1'b1;
        dpulse <= 1'b1;
        rd <= 1'b1;
        @(posedge hclk);
        abort <= 1'b0;
        fpulse <= 1'b0;
        dpulse <= 1'b0;
        rd <= 1'b0;
        @(posedge hclk);
        #1;
        check({led.fault, led.data, led.master, led.busy}, 4'hf);
        mst <= 1'b0;
        repeat (220) @(posedge hclk);
        #1;
        check({led.fault, led.data, led.master, led.busy}, 4'h0);
        for (ph = 0; ph < 2; ph++) begin
            @(posedge hclk);
            bus_b <= ph[0];
            repeat (2) @(posedge hclk);
            #1;
            a_ok = 1'b1;
            tg = 0;
            prev = ph[0] ? led.bus_a : led.bus_b;
            for (n = 0; n < 40; n++) begin
                @(posedge hclk);
                #1;
                a_ok = a_ok & (ph[0] ? led.bus_b : led.bus_a);
                if ((ph[0] ? led.bus_a : led.bus_b) !== prev) tg++;
                prev = ph[0] ? led.bus_a : led.bus_b;
            end
            check({a_ok, 1'(tg > 2)}, 2'b11);
        end
        $display("Indicator test done");
    endtask : t_leds

    task automatic t_resample();
        i_bpc_panel_model.commission(8'h64, 1'b0);
        rd_chk(BPC_CONFIG_OFS, cfgw(8'h5a, 3'h7, 0, 1, 0, 1));
        do_reset();
        rd_chk(BPC_CONFIG_OFS, cfgw(8'h64, 3'h7, 0, 1, 0, 0));
        rd_chk(BPC_IRQ_STAT_OFS, 32'h8);
        i_bpc_panel_model.commission(8'h63, 1'b1);
        do_reset();
        rd_chk(BPC_CONFIG_OFS, cfgw(8'h63, 3'h7, 0, 0, 0, 1));
        @(posedge hclk);
        tba <= 3'h7;
        tel(8'h64);
        check({hp, hs}, 2'b00);
        tel(8'h63);
        check({hp, hs}, 2'b10);
        $display("Resample test done");
    endtask : t_resample

    ////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        t_capture();
        t_match();
        t_idle();
        t_leds();
        t_resample();
        give_verdict();
    end
endmodule : tb_bpc_config_capture
`default_nettype wire
